// [pkg/dis_map.svh]
/*
  Register offsets, reset values and codes for the drive input start logic.
  Assumes a 32-bit Avalon-MM slave with word-aligned byte addresses.
*/
// What this block does
// - A function activates when its assigned input goes high; inputs may carry several.
// - Factory defaults map inputs one to six to start, reverse, speeds, reset, pid block.
// - Fixed speed one and two inputs together select fixed speed three.
// - Mode 3 starts clockwise or anticlockwise from two inputs, interlocked exclusive OR.
// - Mode 0 behaves like mode 3 plus auto restart when restart enable is one.
// - In auto restart mode a held start level restarts without a rising edge.
// - Mode 1 uses forward input as start, second start input selects reverse.
// - Mode 2 starts and stops on momentary pulses and holds run state between.
// - Selection code 0 deactivates, codes 1 to 6 select inputs; forward default 1.
// - Stop or reverse start selection uses same encoding and defaults to code 2.
// - Direction flip input reverses field direction; its selection defaults to 0.
// - Normally open external fault input raises a fault; default deactivated.
`ifndef DIS_MAP_SVH
`define DIS_MAP_SVH

// ============================================================
// Register offsets
`define DIS_OFS_MODE 8'h00
`define DIS_OFS_FWD_SEL 8'h04
`define DIS_OFS_REV_SEL 8'h08
`define DIS_OFS_FLIP_SEL 8'h0C
`define DIS_OFS_FAULT_SEL 8'h10
`define DIS_OFS_SPD1_SEL 8'h14
`define DIS_OFS_SPD2_SEL 8'h18
`define DIS_OFS_ACK_SEL 8'h1C
`define DIS_OFS_PID_SEL 8'h20
`define DIS_OFS_RESTART 8'h24
`define DIS_OFS_STATUS 8'h28
`define DIS_OFS_IRQ_STAT 8'h2C
`define DIS_OFS_IRQ_CLR 8'h30
`define DIS_OFS_IRQ_EN 8'h34

// ============================================================
// Reset values
`define DIS_RST_MODE 8'h03
`define DIS_RST_FWD_SEL 8'h01
`define DIS_RST_REV_SEL 8'h02
`define DIS_RST_FLIP_SEL 8'h00
`define DIS_RST_FAULT_SEL 8'h00
`define DIS_RST_SPD1_SEL 8'h03
`define DIS_RST_SPD2_SEL 8'h04
`define DIS_RST_ACK_SEL 8'h05
`define DIS_RST_PID_SEL 8'h06
`define DIS_RST_RESTART 1'h0

// ============================================================
// Status bit positions
`define DIS_ST_RUN 0
`define DIS_ST_REVERSE 1
`define DIS_ST_FAULT 2
`define DIS_ST_PID_BLOCK 3
`define DIS_ST_SPD_LO 4
`define DIS_ST_SPD_HI 5
`define DIS_IRQ_START 0
`define DIS_IRQ_STOP 1
`define DIS_IRQ_FAULT 2
`define DIS_IRQ_ACK 3

// ============================================================
// Fixed speed codes
`define DIS_SPD_NONE 2'h0
`define DIS_SPD_ONE 2'h1
`define DIS_SPD_TWO 2'h2
`define DIS_SPD_THREE 2'h3

`endif

// [pkg/dis_pkg.sv]
/*
  Types shared by the drive input start logic.
  Assumes the constants header is included alongside.
*/
package dis_pkg;
  // ============================================================
  // Start/stop modes
  typedef enum logic [7:0] {
    DIS_MODE_RESTART = 8'h00,
    DIS_MODE_DIR_SEL = 8'h01,
    DIS_MODE_PULSE = 8'h02,
    DIS_MODE_TWO_WIRE = 8'h03
  } dis_mode_t;

  // ============================================================
  // Run state machine
  typedef enum logic [1:0] {
    DIS_ST_IDLE = 2'b00,
    DIS_ST_FWD = 2'b01,
    DIS_ST_REV = 2'b10,
    DIS_ST_FAULTED = 2'b11
  } dis_state_t;
endpackage : dis_pkg

// [rtl/dis_input_sync.sv]
/*
  Two-stage synchroniser with a rising-edge detect taken from the synced level.
  Assumes raw control inputs are otherwise asynchronous to the clock.
*/
`timescale 1ns/100ps
module dis_input_sync #(
  parameter int WIDTH = 6
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic [WIDTH-1:0] raw,
  output logic [WIDTH-1:0] level,
  output logic [WIDTH-1:0] rise
);
  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] last;

  // ============================================================
  // Synchronise
  // The first stage feeds only the second stage, so metastability stays contained.
  always_ff @(posedge clk) begin
    if (srst) begin
      stage1 <= '0;
      level <= '0;
      last <= '0;
    end else begin
      stage1 <= raw;
      level <= stage1;
      last <= level;
    end
  end

  assign rise = level & ~last;
endmodule : dis_input_sync

// [rtl/dis_func_route.sv]
/*
  Routes the synced input levels and edges onto one function by selection code.
  Assumes codes above six behave as deactivated.
*/
`timescale 1ns/100ps
module dis_func_route (
  input wire logic [7:0] sel,
  input wire logic [5:0] level,
  input wire logic [5:0] rise,
  output logic active,
  output logic edge_hit
);
  // ============================================================
  // Code 0 and out-of-range codes always read inactive.
  always_comb begin
    active = 1'b0;
    edge_hit = 1'b0;
    if (sel >= 8'h01 && sel <= 8'h06) begin
      active = level[sel[2:0] - 3'h1];
      edge_hit = rise[sel[2:0] - 3'h1];
    end
  end
endmodule : dis_func_route

// [rtl/dis_start_logic.sv]
/*
  Start/stop and digital input function assignment logic of a drive, with an
  Avalon-MM register slave and a level interrupt.
  Assumes inputs are already level-shifted from 24 V source wiring to logic.
*/
// Decided for this implementation: the register offsets and register access over Avalon-MM.
`timescale 1ns/100ps
`include "dis_map.svh"
module dis_start_logic
  import dis_pkg::*;
(
  input wire logic CLK_SYS,
  input wire logic SRST,
  input wire logic [5:0] DIG_IN,
  input wire logic FAULT_CLEAR,
  input wire logic [5:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [3:0] AVS_BYTEENABLE,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  output logic RUN,
  output logic REVERSE,
  output logic FAULT,
  output logic PID_BLOCK,
  output logic FAULT_ACK,
  output logic [1:0] FIXED_SPEED,
  output logic IRQ
);
  logic [7:0] start_stop_logic_select;
  logic [7:0] forward_start_input_select;
  logic [7:0] stop_reverse_input_select;
  logic [7:0] direction_flip_input_select;
  logic [7:0] ext_fault_no_input_select;
  logic [7:0] speed_one_select;
  logic [7:0] speed_two_select;
  logic [7:0] ack_select;
  logic [7:0] pid_select;
  logic restart_enable_setting;
  logic [3:0] irq_stat;
  logic [3:0] irq_en;
  logic [5:0] level;
  logic [5:0] rise;
  logic [7:0] f_lvl;
  logic [7:0] f_edge;
  logic [7:0] sel_bank [8];
  dis_state_t state;
  dis_state_t next_state;
  logic access;
  logic ack_phase;
  logic wr;
  logic [3:0] ev;
  logic [3:0] clr_mask;
  logic fault_src;

  // ============================================================
  // Helpers
  function automatic logic [7:0] byte_offset(input logic [5:0] word_addr);
    byte_offset = {word_addr, 2'b00};
  endfunction : byte_offset

  function automatic logic is_running(input dis_state_t st);
    is_running = (st == DIS_ST_FWD) || (st == DIS_ST_REV);
  endfunction : is_running

  // ============================================================
  // Input synchronisation and function routing
  dis_input_sync #(.WIDTH(6)) u_sync (
    .clk(CLK_SYS),
    .srst(SRST),
    .raw(DIG_IN),
    .level(level),
    .rise(rise)
  );

  assign sel_bank[0] = forward_start_input_select;
  assign sel_bank[1] = stop_reverse_input_select;
  assign sel_bank[2] = direction_flip_input_select;
  assign sel_bank[3] = ext_fault_no_input_select;
  assign sel_bank[4] = speed_one_select;
  assign sel_bank[5] = speed_two_select;
  assign sel_bank[6] = ack_select;
  assign sel_bank[7] = pid_select;

  // Every function looks at the same input set, so one input can feed several.
  for (genvar g = 0; g < 8; g++) begin : g_route
    dis_func_route u_route (
      .sel(sel_bank[g]),
      .level(level),
      .rise(rise),
      .active(f_lvl[g]),
      .edge_hit(f_edge[g])
    );
  end

  // ============================================================
  // Avalon-MM slave
  // One wait cycle on every access keeps read data registered and timing simple.
  assign access = (AVS_READ | AVS_WRITE) & ~ack_phase;
  assign AVS_WAITREQUEST = (AVS_READ | AVS_WRITE) & ~ack_phase;
  assign wr = AVS_WRITE & ack_phase & AVS_BYTEENABLE[0];

  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      ack_phase <= 1'b0;
    end else begin
      ack_phase <= access;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      start_stop_logic_select <= `DIS_RST_MODE;
      forward_start_input_select <= `DIS_RST_FWD_SEL;
      stop_reverse_input_select <= `DIS_RST_REV_SEL;
      direction_flip_input_select <= `DIS_RST_FLIP_SEL;
      ext_fault_no_input_select <= `DIS_RST_FAULT_SEL;
      speed_one_select <= `DIS_RST_SPD1_SEL;
      speed_two_select <= `DIS_RST_SPD2_SEL;
      ack_select <= `DIS_RST_ACK_SEL;
      pid_select <= `DIS_RST_PID_SEL;
      restart_enable_setting <= `DIS_RST_RESTART;
      irq_en <= 4'h0;
    end else if (wr) begin
      case (byte_offset(AVS_ADDRESS))
        `DIS_OFS_MODE: start_stop_logic_select <= AVS_WRITEDATA[7:0];
        `DIS_OFS_FWD_SEL: forward_start_input_select <= AVS_WRITEDATA[7:0];
        `DIS_OFS_REV_SEL: stop_reverse_input_select <= AVS_WRITEDATA[7:0];
        `DIS_OFS_FLIP_SEL: direction_flip_input_select <= AVS_WRITEDATA[7:0];
        `DIS_OFS_FAULT_SEL: ext_fault_no_input_select <= AVS_WRITEDATA[7:0];
        `DIS_OFS_SPD1_SEL: speed_one_select <= AVS_WRITEDATA[7:0];
        `DIS_OFS_SPD2_SEL: speed_two_select <= AVS_WRITEDATA[7:0];
        `DIS_OFS_ACK_SEL: ack_select <= AVS_WRITEDATA[7:0];
        `DIS_OFS_PID_SEL: pid_select <= AVS_WRITEDATA[7:0];
        `DIS_OFS_RESTART: restart_enable_setting <= AVS_WRITEDATA[0];
        `DIS_OFS_IRQ_EN: irq_en <= AVS_WRITEDATA[3:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      AVS_READDATA <= 32'h0000_0000;
    end else if (access && AVS_READ) begin
      case (byte_offset(AVS_ADDRESS))
        `DIS_OFS_MODE: AVS_READDATA <= {24'h0, start_stop_logic_select};
        `DIS_OFS_FWD_SEL: AVS_READDATA <= {24'h0, forward_start_input_select};
        `DIS_OFS_REV_SEL: AVS_READDATA <= {24'h0, stop_reverse_input_select};
        `DIS_OFS_FLIP_SEL: AVS_READDATA <= {24'h0, direction_flip_input_select};
        `DIS_OFS_FAULT_SEL: AVS_READDATA <= {24'h0, ext_fault_no_input_select};
        `DIS_OFS_SPD1_SEL: AVS_READDATA <= {24'h0, speed_one_select};
        `DIS_OFS_SPD2_SEL: AVS_READDATA <= {24'h0, speed_two_select};
        `DIS_OFS_ACK_SEL: AVS_READDATA <= {24'h0, ack_select};
        `DIS_OFS_PID_SEL: AVS_READDATA <= {24'h0, pid_select};
        `DIS_OFS_RESTART: AVS_READDATA <= {31'h0, restart_enable_setting};
        `DIS_OFS_STATUS: AVS_READDATA <= {26'h0, FIXED_SPEED, PID_BLOCK, FAULT, REVERSE, RUN};
        `DIS_OFS_IRQ_STAT: AVS_READDATA <= {28'h0, irq_stat};
        `DIS_OFS_IRQ_EN: AVS_READDATA <= {28'h0, irq_en};
        default: AVS_READDATA <= 32'h0000_0000;
      endcase
    end
  end

  // ============================================================
  // Fault latch
  // The fault holds until an acknowledge edge or FAULT_CLEAR; a still-active fault input wins over the clear.
  assign fault_src = f_lvl[3];

  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      FAULT <= 1'b0;
    end else if (fault_src) begin
      FAULT <= 1'b1;
    end else if (f_edge[6] || FAULT_CLEAR) begin
      FAULT <= 1'b0;
    end
  end

  // ============================================================
  // Start/stop state machine
  always_comb begin
    next_state = state;
    case (state)
      DIS_ST_IDLE: begin
        case (start_stop_logic_select)
          DIS_MODE_TWO_WIRE, DIS_MODE_RESTART: begin
            // Exclusive OR interlock: both held means no start.
            if (f_edge[0] && !f_lvl[1]) next_state = DIS_ST_FWD;
            else if (f_edge[1] && !f_lvl[0]) next_state = DIS_ST_REV;
          end
          DIS_MODE_DIR_SEL: begin
            if (f_edge[0]) next_state = f_lvl[1] ? DIS_ST_REV : DIS_ST_FWD;
          end
          DIS_MODE_PULSE: begin
            if (f_edge[0] && !f_lvl[1]) next_state = DIS_ST_FWD;
          end
          default: next_state = DIS_ST_IDLE;
        endcase
      end
      DIS_ST_FWD, DIS_ST_REV: begin
        case (start_stop_logic_select)
          DIS_MODE_TWO_WIRE, DIS_MODE_RESTART: begin
            if (state == DIS_ST_FWD && (!f_lvl[0] || f_lvl[1])) next_state = DIS_ST_IDLE;
            if (state == DIS_ST_REV && (!f_lvl[1] || f_lvl[0])) next_state = DIS_ST_IDLE;
          end
          DIS_MODE_DIR_SEL: begin
            if (!f_lvl[0]) next_state = DIS_ST_IDLE;
            else next_state = f_lvl[1] ? DIS_ST_REV : DIS_ST_FWD;
          end
          DIS_MODE_PULSE: begin
            if (f_edge[1]) next_state = DIS_ST_IDLE;
          end
          default: next_state = DIS_ST_IDLE;
        endcase
      end
      DIS_ST_FAULTED: begin
        if (!FAULT) begin
          // Auto restart accepts a held level, no fresh edge needed.
          if (start_stop_logic_select == DIS_MODE_RESTART && restart_enable_setting) begin
            if (f_lvl[0] && !f_lvl[1]) next_state = DIS_ST_FWD;
            else if (f_lvl[1] && !f_lvl[0]) next_state = DIS_ST_REV;
            else next_state = DIS_ST_IDLE;
          end else begin
            next_state = DIS_ST_IDLE;
          end
        end
      end
      default: next_state = DIS_ST_IDLE;
    endcase
    if (fault_src || FAULT) next_state = DIS_ST_FAULTED;
  end

  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      state <= DIS_ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // ============================================================
  // Outputs
  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      RUN <= 1'b0;
      REVERSE <= 1'b0;
      PID_BLOCK <= 1'b0;
      FAULT_ACK <= 1'b0;
      FIXED_SPEED <= `DIS_SPD_NONE;
    end else begin
      RUN <= is_running(next_state);
      REVERSE <= (next_state == DIS_ST_REV) ^ f_lvl[2];
      PID_BLOCK <= f_lvl[7];
      FAULT_ACK <= f_edge[6];
      FIXED_SPEED <= {f_lvl[5], f_lvl[4]};
    end
  end

  // ============================================================
  // Interrupts
  assign ev[`DIS_IRQ_START] = !is_running(state) &&
                              is_running(next_state);
  assign ev[`DIS_IRQ_STOP] = is_running(state) &&
                             (next_state == DIS_ST_IDLE);
  assign ev[`DIS_IRQ_FAULT] = fault_src && !FAULT;
  assign ev[`DIS_IRQ_ACK] = f_edge[6];
  assign clr_mask = (wr && byte_offset(AVS_ADDRESS) == `DIS_OFS_IRQ_CLR) ? AVS_WRITEDATA[3:0] : 4'h0;

  // A new event in the cycle of its clear survives.
  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      irq_stat <= 4'h0;
    end else begin
      irq_stat <= (irq_stat & ~clr_mask) | ev;
    end
  end

  assign IRQ = |(irq_stat & irq_en);
endmodule : dis_start_logic

// [test/dis_switch_bank.sv]
/*
  Model of the switches or PLC outputs that drive the six control inputs.
  Assumes the bench sets the wanted switch levels just after a clock edge.
*/
`timescale 1ns/100ps
module dis_switch_bank (
  input wire logic clk,
  input wire logic [5:0] press,
  output logic [5:0] level
);
  // ============================================================
  // Switch contacts
  // One register stands in for contact travel; a level or a one-cycle pulse passes as set.
  always_ff @(posedge clk) begin
    level <= press;
  end
endmodule : dis_switch_bank

// [test/dis_start_logic_checker.sv]
/*
  Concurrent checks on the ports of the drive input start logic.
  Assumes one clock domain and a synchronous active-high reset.
*/
`timescale 1ns/100ps
module dis_start_logic_checker (
  input wire logic CLK_SYS,
  input wire logic SRST,
  input wire logic [5:0] DIG_IN,
  input wire logic [5:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_READDATA,
  input wire logic AVS_WAITREQUEST,
  input wire logic RUN,
  input wire logic FAULT,
  input wire logic PID_BLOCK,
  input wire logic FAULT_ACK,
  input wire logic [1:0] FIXED_SPEED,
  input wire logic IRQ
);
  // ============================================================
  // Properties
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (SRST);
  property p_run_cause;
    $rose(RUN) |-> ($past(DIG_IN, 3) | $past(DIG_IN, 4)) != 6'h00;
  endproperty
  property p_speed_cause;
    FIXED_SPEED != 2'h0 |-> $past(DIG_IN, 3) != 6'h00;
  endproperty
  property p_pid_cause;
    PID_BLOCK |-> $past(DIG_IN, 3) != 6'h00;
  endproperty
  property p_fault_cause;
    $rose(FAULT) |-> $past(DIG_IN, 3) != 6'h00;
  endproperty
  property p_ack_edge;
    FAULT_ACK |-> ($past(DIG_IN, 3) & ~$past(DIG_IN, 4)) != 6'h00;
  endproperty
  property p_ack_pulse;
    FAULT_ACK |=> !FAULT_ACK;
  endproperty
  property p_wait_first;
    (AVS_READ || AVS_WRITE) && !$past(AVS_READ || AVS_WRITE) |-> AVS_WAITREQUEST;
  endproperty
  property p_wait_once;
    AVS_WAITREQUEST |=> !AVS_WAITREQUEST;
  endproperty
  property p_upper_zero;
    AVS_READ && !AVS_WAITREQUEST |-> AVS_READDATA[31:8] == 24'h000000;
  endproperty
  // ============================================================
  // Assertions
  a_run_cause: assert property (p_run_cause) else $error("run rose without input");
  a_speed_cause: assert property (p_speed_cause) else $error("speed without input");
  a_pid_cause: assert property (p_pid_cause) else $error("pid block without input");
  a_fault_cause: assert property (p_fault_cause) else $error("fault without input");
  a_ack_edge: assert property (p_ack_edge) else $error("ack without rising edge");
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than a cycle");
  a_wait_first: assert property (p_wait_first) else $error("no wait on first cycle");
  a_wait_once: assert property (p_wait_once) else $error("wait held too long");
  a_upper_zero: assert property (p_upper_zero) else $error("read data upper bits set");
  c_run: cover property ($rose(RUN));
  c_fault: cover property ($rose(FAULT));
  c_speed3: cover property (FIXED_SPEED == 2'h3);
  c_irq: cover property ($rose(IRQ));
endmodule : dis_start_logic_checker

bind dis_start_logic dis_start_logic_checker i_dis_start_logic_checker (
  .CLK_SYS(CLK_SYS), .SRST(SRST), .DIG_IN(DIG_IN), .AVS_ADDRESS(AVS_ADDRESS),
  .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE), .AVS_READDATA(AVS_READDATA),
  .AVS_WAITREQUEST(AVS_WAITREQUEST), .RUN(RUN), .FAULT(FAULT), .PID_BLOCK(PID_BLOCK),
  .FAULT_ACK(FAULT_ACK), .FIXED_SPEED(FIXED_SPEED), .IRQ(IRQ)
);

// [test/test_dis_start_logic.sv]
/*
  Self-checking bench of the drive input start logic over its register bus.
  Assumes the switch model sits between the bench and the digital inputs.
*/
`timescale 1ns/100ps
`include "dis_map.svh"
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin errors++; \
  $display("BAD %0t got %0h expected %0h", $time, a, b); end end
module test_dis_start_logic;
  import dis_pkg::*;
  logic clk_sys, srst, fault_clear, avs_read, avs_write, run, reverse, fault;
  logic pid_block, fault_ack, irq, wait_req, ack_seen;
  logic [5:0] press, dig_in, avs_address;
  logic [31:0] avs_writedata, avs_readdata, q;
  logic [1:0] fixed_speed;
  int errors, comparisons, cycles;
  logic [7:0] rst_tab [10] = '{8'h03, 8'h01, 8'h02, 8'h00, 8'h00, 8'h03, 8'h04, 8'h05,
    8'h06, 8'h00};
  dis_switch_bank i_dis_switch_bank (.clk(clk_sys), .press(press), .level(dig_in));
  dis_start_logic i_dis_start_logic (
    .CLK_SYS(clk_sys), .SRST(srst), .DIG_IN(dig_in), .FAULT_CLEAR(fault_clear),
    .AVS_ADDRESS(avs_address), .AVS_READ(avs_read), .AVS_WRITE(avs_write),
    .AVS_WRITEDATA(avs_writedata), .AVS_BYTEENABLE(4'hF), .AVS_READDATA(avs_readdata),
    .AVS_WAITREQUEST(wait_req), .RUN(run), .REVERSE(reverse), .FAULT(fault),
    .PID_BLOCK(pid_block), .FAULT_ACK(fault_ack), .FIXED_SPEED(fixed_speed), .IRQ(irq)
  );
  // ============================================================
  // Clock, timeout and sticky capture of the one-cycle acknowledge pulse
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cycles++;
    if (srst) ack_seen <= 1'b0;
    else if (fault_ack === 1'b1) ack_seen <= 1'b1;
    if (cycles == 20000) begin
      errors++;
      end_of_test();
    end
  end
  // ============================================================
  // Bus and switch tasks
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    avs_read <= !w;
    avs_write <= w;
    avs_address <= a[7:2];
    avs_writedata <= {24'h000000, d};
    @(posedge clk_sys);
    while (wait_req !== 1'b0) @(posedge clk_sys);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : acc
  task automatic sw(input logic [5:0] v, input logic pulse);
    @(posedge clk_sys);
    press <= v;
    if (pulse) begin
      @(posedge clk_sys);
      press <= 6'h00;
    end
    repeat (5) @(posedge clk_sys);
    @(negedge clk_sys);
  endtask : sw
  task automatic done(input string name);
    $display("test %s finished", name);
  endtask : done
  task automatic end_of_test();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : end_of_test
  // ============================================================
  // Tests
  initial begin
    {srst, fault_clear, avs_read, avs_write} = 4'b1000;
    press = 6'h00;
    avs_address = 6'h00;
    avs_writedata = 32'h00000000;
    repeat (20) @(posedge clk_sys);
    srst <= 1'b0;
    for (int i = 0; i < 10; i++) begin
      acc(1'b0, 8'(i * 4), 8'h00);
      `CHK(q, {24'h000000, rst_tab[i]})
    end
    acc(1'b0, 8'h38, 8'h00);
    `CHK(q, 32'h00000000)
    done("defaults");
    sw(6'h01, 1'b0);
    `CHK({run, reverse}, 2'b10)
    sw(6'h03, 1'b0);
    `CHK(run, 1'b0)
    sw(6'h00, 1'b0);
    sw(6'h02, 1'b0);
    `CHK({run, reverse}, 2'b11)
    sw(6'h00, 1'b0);
    done("two wire");
    sw(6'h04, 1'b0);
    `CHK(fixed_speed, 2'h1)
    sw(6'h0C, 1'b0);
    `CHK(fixed_speed, 2'h3)
    sw(6'h30, 1'b0);
    `CHK({pid_block, fixed_speed, ack_seen}, 4'b1001)
    acc(1'b1, `DIS_OFS_SPD2_SEL, 8'h03);
    sw(6'h04, 1'b0);
    `CHK(fixed_speed, 2'h3)
    acc(1'b1, `DIS_OFS_SPD2_SEL, 8'h04);
    acc(1'b1, `DIS_OFS_FLIP_SEL, 8'h06);
    sw(6'h21, 1'b0);
    `CHK({run, reverse}, 2'b11)
    sw(6'h00, 1'b0);
    acc(1'b1, `DIS_OFS_FLIP_SEL, 8'h00);
    done("functions");
    acc(1'b1, `DIS_OFS_FAULT_SEL, 8'h04);
    acc(1'b1, `DIS_OFS_IRQ_EN, 8'h04);
    sw(6'h01, 1'b0);
    sw(6'h09, 1'b0);
    `CHK({fault, run, irq}, 3'b101)
    acc(1'b0, `DIS_OFS_IRQ_STAT, 8'h00);
    `CHK(q[3:0], 4'hF)
    acc(1'b0, `DIS_OFS_STATUS, 8'h00);
    `CHK(q, 32'h00000024)
    sw(6'h00, 1'b0);
    @(posedge clk_sys);
    fault_clear <= 1'b1;
    sw(6'h00, 1'b0);
    `CHK(fault, 1'b0)
    @(posedge clk_sys);
    fault_clear <= 1'b0;
    acc(1'b1, `DIS_OFS_IRQ_CLR, 8'h0F);
    acc(1'b0, `DIS_OFS_IRQ_STAT, 8'h00);
    `CHK(q, 32'h00000000)
    `CHK(irq, 1'b0)
    acc(1'b1, `DIS_OFS_IRQ_EN, 8'h00);
    `CHK(irq, 1'b0)
    done("fault and interrupt");
    acc(1'b1, `DIS_OFS_FWD_SEL, 8'h00);
    sw(6'h01, 1'b0);
    `CHK(run, 1'b0)
    sw(6'h00, 1'b0);
    acc(1'b1, `DIS_OFS_FWD_SEL, 8'h01);
    acc(1'b1, `DIS_OFS_MODE, 8'h01);
    sw(6'h01, 1'b0);
    `CHK({run, reverse}, 2'b10)
    sw(6'h03, 1'b0);
    `CHK({run, reverse}, 2'b11)
    sw(6'h00, 1'b0);
    acc(1'b1, `DIS_OFS_MODE, 8'h02);
    sw(6'h01, 1'b1);
    `CHK(run, 1'b1)
    sw(6'h00, 1'b0);
    `CHK(run, 1'b1)
    sw(6'h02, 1'b1);
    `CHK(run, 1'b0)
    done("modes one and two");
    acc(1'b1, `DIS_OFS_MODE, 8'h00);
    acc(1'b1, `DIS_OFS_RESTART, 8'h01);
    sw(6'h01, 1'b0);
    `CHK(run, 1'b1)
    sw(6'h09, 1'b0);
    `CHK({fault, run}, 2'b10)
    sw(6'h01, 1'b0);
    `CHK({fault, run}, 2'b10)
    sw(6'h11, 1'b0);
    `CHK({fault, run}, 2'b01)
    sw(6'h00, 1'b0);
    `CHK(run, 1'b0)
    acc(1'b1, `DIS_OFS_MODE, 8'h04);
    sw(6'h01, 1'b0);
    `CHK(run, 1'b0)
    sw(6'h00, 1'b0);
    done("restart");
    end_of_test();
  end
endmodule : test_dis_start_logic
